// File: rtl/wgt_timer_top.sv
// Notes on behaviour
// - Wake interval = wake clock period x wake divider x 16-bit value (two bytes).
// - Stay-awake time = wake clock period x wake divider x 8-bit value.
// - Timer two clock select bit 5: 0 wake clock, 1 2MHz.
// - Timer one clock select bit 1: 0 wake clock, 1 2MHz.
// - Bit 4 runs timer two: 1 starts or resumes, 0 pauses keeping count.
// - Bit 0 runs timer one: 1 starts or resumes, 0 pauses keeping count.
// - A general timer clears its own run bit on time-out.
// - Timer two prescale bits 7:4: 0 none, 1..9 128..32768, else 65536.
// - Timer one prescale bits 3:0 decode the same way as timer two.
// - Wake clock is external input when select is 0, RC oscillator at 1.
// - Timer one period = its clock period x prescale x 8-bit period value.
// - Timer two period = its clock period x prescale x 8-bit period value.
`timescale 1ns/1ps
`default_nettype none

module wgt_timer_top
  import wgt_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  input  wire logic [31:0]     s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  input  wire logic            ext_wake_clk,
  input  wire logic            rc_wake_clk,
  input  wire logic            ref_2mhz_clk,
  output logic [wgt_pkg::EV_N-1:0] timeout_event,
  output logic                 stay_awake_active,
  output logic                 irq
);

  import wgt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]      wake_ctrl_q;
  logic [7:0]      wake_prescale_q;
  logic [7:0]      interval_hi_q;
  logic [7:0]      interval_lo_q;
  logic [7:0]      stay_q;
  logic [7:0]      gt_config_q;
  logic [7:0]      gt_config_d;
  logic [7:0]      gt_prescale_q;
  logic [7:0]      period_q [2];
  logic [EV_N-1:0] status_q;
  logic [EV_N-1:0] status_d;
  logic [EV_N-1:0] mask_q;
  logic            stay_active_q;
  logic [EV_N-1:0] event_q;
  logic            irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic       aw_hold_q;
  logic [7:0] aw_idx_q;
  logic       w_hold_q;
  logic [7:0] w_data_q;
  logic       w_lane_q;
  logic       awready_q;
  logic       wready_q;
  logic       bvalid_q;
  logic [1:0] bresp_q;

  logic       aw_take;
  logic       w_take;
  logic       aw_have;
  logic       w_have;
  logic       do_write;
  logic       aw_hold_d;
  logic       w_hold_d;
  logic       bvalid_d;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_lane;
  logic       wr_en;
  logic       wr_mapped;

  assign aw_take   = s_axi_awvalid && awready_q;
  assign w_take    = s_axi_wvalid && wready_q;
  assign aw_have   = aw_hold_q || aw_take;
  assign w_have    = w_hold_q || w_take;
  assign do_write  = aw_have && w_have && !bvalid_q;
  assign aw_hold_d = aw_have && !do_write;
  assign w_hold_d  = w_have && !do_write;
  assign bvalid_d  = do_write || (bvalid_q && !s_axi_bready);
  assign wr_idx    = aw_take ? s_axi_awaddr[9:2] : aw_idx_q;
  assign wr_data   = w_take ? s_axi_wdata[7:0] : w_data_q;
  assign wr_lane   = w_take ? s_axi_wstrb[0] : w_lane_q;
  assign wr_en     = do_write && wr_lane && (aw_take
                     ? (s_axi_awaddr[31:10] == '0) : 1'b1);

  function automatic logic mapped(input logic [7:0] idx);
    return (idx >= IDX_WAKE_CTRL && idx <= IDX_T2_PERIOD)
        || idx == IDX_STATUS || idx == IDX_MASK;
  endfunction

  assign wr_mapped = mapped(wr_idx)
                     && (!aw_take || s_axi_awaddr[31:10] == '0);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      aw_idx_q  <= '0;
      w_data_q  <= '0;
      w_lane_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      if (aw_take)
        aw_idx_q <= (s_axi_awaddr[31:10] == '0) ? s_axi_awaddr[9:2] : 8'hFF;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      awready_q <= !aw_hold_d && !bvalid_d;
      wready_q  <= !w_hold_d && !bvalid_d;
      bvalid_q  <= bvalid_d;
      if (do_write)
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        ar_take;
  logic        rvalid_d;
  logic [7:0]  rd_idx;
  logic        rd_ok;
  logic [7:0]  rd_val;

  assign ar_take  = s_axi_arvalid && arready_q;
  assign rvalid_d = ar_take || (rvalid_q && !s_axi_rready);
  assign rd_idx   = s_axi_araddr[9:2];
  assign rd_ok    = mapped(rd_idx) && (s_axi_araddr[31:10] == '0);
  assign rd_val   =
      (rd_idx == IDX_WAKE_CTRL)     ? (wake_ctrl_q
                                       | {2'h0, stay_active_q, 5'h00}) & 8'hFF
    : (rd_idx == IDX_WAKE_PRESCALE) ? wake_prescale_q
    : (rd_idx == IDX_INTERVAL_HI)   ? interval_hi_q
    : (rd_idx == IDX_INTERVAL_LO)   ? interval_lo_q
    : (rd_idx == IDX_STAY)          ? stay_q
    : (rd_idx == IDX_GT_CONFIG)     ? gt_config_q
    : (rd_idx == IDX_GT_PRESCALE)   ? gt_prescale_q
    : (rd_idx == IDX_T1_PERIOD)     ? period_q[0]
    : (rd_idx == IDX_T2_PERIOD)     ? period_q[1]
    : (rd_idx == IDX_STATUS)        ? {4'h0, status_q}
    : (rd_idx == IDX_MASK)          ? {4'h0, mask_q}
    : 8'h00;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= {24'h000000, rd_ok ? rd_val : 8'h00};
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source edges, pins are synchronous to core_clk
  logic [2:0] src_q;
  logic [2:0] src_p;
  logic       ext_edge;
  logic       rc_edge;
  logic       fast_edge;
  logic       wake_edge;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      src_q <= '0;
      src_p <= '0;
    end
    else
    begin
      src_q <= {ref_2mhz_clk, rc_wake_clk, ext_wake_clk};
      src_p <= src_q;
    end
  end

  assign ext_edge  = src_q[0] && !src_p[0];
  assign rc_edge   = src_q[1] && !src_p[1];
  assign fast_edge = src_q[2] && !src_p[2];
  assign wake_edge = wake_ctrl_q[WAKE_CLK_SEL_BIT] ? rc_edge
                                                   : ext_edge;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up interval and stay-awake timers
  logic        wake_en;
  logic        wake_run;
  logic        wake_tick;
  logic        wake_hit;
  logic        stay_hit;
  logic [15:0] interval_val;

  assign wake_en      = wake_ctrl_q[WAKE_EN_BIT];
  assign wake_run     = wake_en || stay_active_q;
  assign interval_val = {interval_hi_q, interval_lo_q};

  wgt_prescaler #(.DW(DIV_W)) u_wake_pre (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (!wake_run),
    .run      (wake_run),
    .src_tick (wake_edge),
    .divisor  (wake_div(wake_prescale_q[3:0])),
    .tick_out (wake_tick)
  );

  wgt_counter #(.W(16)) u_wake_cnt (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (!wake_en),
    .run      (wake_en),
    .tick     (wake_tick),
    .period   (interval_val),
    .hit      (wake_hit)
  );

  wgt_counter #(.W(8)) u_stay_cnt (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (!stay_active_q),
    .run      (stay_active_q),
    .tick     (wake_tick),
    .period   (stay_q),
    .hit      (stay_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // General purpose timers
  logic [1:0] gt_hit;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_gt
      logic gt_run;
      logic gt_src;
      logic gt_tick;
      assign gt_run = gt_config_q[g*GT_STRIDE + GT_RUN_BIT];
      assign gt_src = gt_config_q[g*GT_STRIDE + GT_SEL_BIT]
                      ? fast_edge : wake_edge;

      wgt_prescaler #(.DW(DIV_W)) u_pre (
        .core_clk (core_clk),
        .reset    (reset),
        .clr      (1'b0),
        .run      (gt_run),
        .src_tick (gt_src),
        .divisor  (gt_div(gt_prescale_q[g*GT_STRIDE +: 4])),
        .tick_out (gt_tick)
      );

      wgt_counter #(.W(8)) u_cnt (
        .core_clk (core_clk),
        .reset    (reset),
        .clr      (1'b0),
        .run      (gt_run),
        .tick     (gt_tick),
        .period   (period_q[g]),
        .hit      (gt_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, self-clearing run bits and event status
  logic            wr_cfg;
  logic [EV_N-1:0] ev_now;
  logic [EV_N-1:0] w1c;

  assign wr_cfg = wr_en && wr_idx == IDX_GT_CONFIG;
  always_comb
  begin
    gt_config_d = gt_config_q;
    if (gt_hit[0])
      gt_config_d[GT_RUN_BIT] = 1'b0;
    if (gt_hit[1])
      gt_config_d[GT_STRIDE + GT_RUN_BIT] = 1'b0;
    if (wr_cfg)
      gt_config_d = wr_data & GT_CONFIG_MASK;
  end

  assign ev_now   = {gt_hit[1], gt_hit[0], stay_hit, wake_hit};
  assign w1c      = (wr_en && wr_idx == IDX_STATUS) ? wr_data[EV_N-1:0] : '0;
  assign status_d = (status_q & ~w1c) | ev_now;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wake_ctrl_q     <= WAKE_CTRL_RESET;
      wake_prescale_q <= REG_RESET;
      interval_hi_q   <= REG_RESET;
      interval_lo_q   <= REG_RESET;
      stay_q          <= REG_RESET;
      gt_config_q     <= REG_RESET;
      gt_prescale_q   <= REG_RESET;
      period_q[0]     <= REG_RESET;
      period_q[1]     <= REG_RESET;
      mask_q          <= '0;
    end
    else
    begin
      gt_config_q <= gt_config_d;
      if (wr_en && wr_idx == IDX_WAKE_CTRL)
        wake_ctrl_q <= wr_data & WAKE_CTRL_MASK;
      if (wr_en && wr_idx == IDX_WAKE_PRESCALE)
        wake_prescale_q <= wr_data;
      if (wr_en && wr_idx == IDX_INTERVAL_HI)
        interval_hi_q <= wr_data;
      if (wr_en && wr_idx == IDX_INTERVAL_LO)
        interval_lo_q <= wr_data;
      if (wr_en && wr_idx == IDX_STAY)
        stay_q <= wr_data;
      if (wr_en && wr_idx == IDX_GT_PRESCALE)
        gt_prescale_q <= wr_data;
      if (wr_en && wr_idx == IDX_T1_PERIOD)
        period_q[0] <= wr_data;
      if (wr_en && wr_idx == IDX_T2_PERIOD)
        period_q[1] <= wr_data;
      if (wr_en && wr_idx == IDX_MASK)
        mask_q <= wr_data[EV_N-1:0];
    end
  end

  // Stay-awake window opens on a wake time-out when enabled
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      stay_active_q <= 1'b0;
      status_q      <= '0;
      event_q       <= '0;
      irq_q         <= 1'b0;
    end
    else
    begin
      if (wake_hit && wake_ctrl_q[STAY_EN_BIT])
        stay_active_q <= 1'b1;
      else if (stay_hit)
        stay_active_q <= 1'b0;
      status_q <= status_d;
      event_q  <= ev_now;
      irq_q    <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;
  assign timeout_event     = event_q;
  assign stay_awake_active = stay_active_q;
  assign irq               = irq_q;

endmodule // wgt_timer_top

`default_nettype wire

// File: common/wgt_pkg.sv
`default_nettype none

package wgt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam int unsigned IDX_W = 8;
  localparam logic [7:0] IDX_WAKE_CTRL     = 8'h2D;
  localparam logic [7:0] IDX_WAKE_PRESCALE = 8'h2E;
  localparam logic [7:0] IDX_INTERVAL_HI   = 8'h2F;
  localparam logic [7:0] IDX_INTERVAL_LO   = 8'h30;
  localparam logic [7:0] IDX_STAY          = 8'h31;
  localparam logic [7:0] IDX_GT_CONFIG     = 8'h32;
  localparam logic [7:0] IDX_GT_PRESCALE   = 8'h33;
  localparam logic [7:0] IDX_T1_PERIOD     = 8'h34;
  localparam logic [7:0] IDX_T2_PERIOD     = 8'h35;
  localparam logic [7:0] IDX_STATUS        = 8'h40;
  localparam logic [7:0] IDX_MASK          = 8'h41;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int unsigned WAKE_CLK_SEL_BIT = 2;
  localparam int unsigned WAKE_EN_BIT      = 4;
  localparam int unsigned STAY_EN_BIT      = 5;
  localparam logic [7:0]  WAKE_CTRL_MASK   = 8'h34;
  localparam logic [7:0]  WAKE_CTRL_RESET  = 8'h04;
  localparam int unsigned GT_RUN_BIT       = 0;
  localparam int unsigned GT_SEL_BIT       = 1;
  localparam int unsigned GT_STRIDE        = 4;
  localparam logic [7:0]  GT_CONFIG_MASK   = 8'h33;
  localparam logic [7:0]  REG_RESET        = 8'h00;

  localparam int unsigned EV_N    = 4;
  localparam int unsigned EV_WAKE = 0;
  localparam int unsigned EV_STAY = 1;
  localparam int unsigned EV_T1   = 2;
  localparam int unsigned EV_T2   = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned DIV_W = 17;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler code decoding
  function automatic logic [16:0] gt_div(input logic [3:0] code);
    if (code == 4'h0)
      return 17'h00001;
    else if (code <= 4'h9)
      return 17'h00001 << ({1'b0, code} + 5'h06);
    else
      return 17'h10000;
  endfunction

  function automatic logic [16:0] wake_div(input logic [3:0] code);
    case (code)
      4'h0:    return 17'h00001;
      4'h9:    return 17'h00002;
      4'hA:    return 17'h00004;
      4'hB:    return 17'h00008;
      4'hC:    return 17'h00010;
      4'hD,
      4'hE,
      4'hF:    return 17'h04000;
      default: return 17'h00001 << ({1'b0, code} + 5'h06);
    endcase
  endfunction

endpackage

`default_nettype wire

// File: rtl/wgt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module wgt_prescaler
  import wgt_pkg::*;
#(
  parameter int unsigned DW = DIV_W
)
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          clr,
  input  wire logic          run,
  input  wire logic          src_tick,
  input  wire logic [DW-1:0] divisor,
  output logic               tick_out
);

  logic [DW-2:0] cnt_q;
  logic [DW-1:0] div_m1;
  logic          last;

  assign div_m1   = divisor - {{(DW-1){1'b0}}, 1'b1};
  assign last     = ({1'b0, cnt_q} == div_m1) || (divisor <= 1);
  assign tick_out = run && src_tick && last;

  // Pausing keeps the partial count so a resume continues exactly
  always_ff @(posedge core_clk)
  begin
    if (reset || clr)
      cnt_q <= '0;
    else if (run && src_tick)
      cnt_q <= last ? '0 : cnt_q + 1'b1;
  end

endmodule // wgt_prescaler

`default_nettype wire

// File: rtl/wgt_counter.sv
`timescale 1ns/1ps
`default_nettype none

module wgt_counter
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         clr,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] period,
  output logic              hit
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_inc;

  assign cnt_inc = cnt_q + {{(W-1){1'b0}}, 1'b1};
  // A period of zero wraps round the full counter range
  assign hit     = run && tick && (cnt_inc == period);

  always_ff @(posedge core_clk)
  begin
    if (reset || clr || hit)
      cnt_q <= '0;
    else if (run && tick)
      cnt_q <= cnt_inc;
  end

endmodule // wgt_counter

`default_nettype wire

// File: testbench/wgt_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module wgt_timer_chk
  import wgt_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            reset,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [wgt_pkg::EV_N-1:0] timeout_event,
  input wire logic            stay_awake_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_b_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write not answered");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_busy_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_event_single: assert property (
    timeout_event != '0 |=> (timeout_event & $past(timeout_event)) == '0)
    else $error("time-out event longer than one cycle");
  chk_stay_start: assert property (
    $rose(stay_awake_active) |-> timeout_event[EV_WAKE])
    else $error("stay-awake started without wake event");
endmodule // wgt_timer_chk

bind wgt_timer_top wgt_timer_chk i_wgt_timer_chk (
  .core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timeout_event(timeout_event),
  .stay_awake_active(stay_awake_active));

`default_nettype wire

// File: testbench/wakeup_and_general_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end

module wakeup_and_general_timers_tb;
  import wgt_pkg::*;
  logic            core_clk = 1'b0;
  logic            reset = 1'b1;
  logic [31:0]     awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic            awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic            arvalid = 1'b0, rready = 1'b0;
  logic            awready, wready, bvalid, arready, rvalid, stay, irq;
  logic [1:0]      bresp, rresp;
  logic [2:0]      src = 3'h0;
  logic [3:0]      wstrb = 4'h1;
  logic [EV_N-1:0] tev;
  int              ev[EV_N] = '{default: 0};
  int              num_errors = 0;
  int              tests_run = 0;

  always #20 core_clk = ~core_clk;

  wgt_timer_top i_wgt_timer_top (
    .core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_wake_clk(src[0]), .rc_wake_clk(src[1]),
    .ref_2mhz_clk(src[2]), .timeout_event(tev), .stay_awake_active(stay),
    .irq(irq));

  always @(posedge core_clk)
    for (int i = 0; i < EV_N; i++)
      if (tev[i] === 1'b1)
        ev[i] <= ev[i] + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= {22'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    `CHK({bvalid, bresp}, {1'b1, er})
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= {22'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    `CHK({rvalid, rresp, rdata}, {1'b1, er, 24'h0, ed})
  endtask

  // Source edges: each high level held two core cycles, each low level five
  task automatic tk(input int s, input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      src[s] <= 1'b1;
      repeat (2) @(posedge core_clk);
      src[s] <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rd(IDX_WAKE_CTRL, WAKE_CTRL_RESET, RESP_OKAY);
    for (int i = 8'h2F; i <= 8'h35; i++)
      rd(8'(i), REG_RESET, RESP_OKAY);
    rd(8'h50, 8'h00, RESP_SLVERR);
    wr(8'h50, 8'h5A, RESP_SLVERR);
    wr(IDX_INTERVAL_HI, 8'h12, RESP_OKAY);
    rd(IDX_INTERVAL_HI, 8'h12, RESP_OKAY);
    wr(IDX_STAY, 8'h56, RESP_OKAY);
    rd(IDX_STAY, 8'h56, RESP_OKAY);
    // Byte lane zero off: answered OKAY, register left alone
    wstrb <= 4'h0;
    wr(IDX_STAY, 8'hAA, RESP_OKAY);
    wstrb <= 4'h1;
    rd(IDX_STAY, 8'h56, RESP_OKAY);
    wr(IDX_GT_CONFIG, 8'hCC, RESP_OKAY);
    rd(IDX_GT_CONFIG, 8'h00, RESP_OKAY);
    // Timer one on the 2 MHz source, no division, period three
    wr(IDX_T1_PERIOD, 8'h03, RESP_OKAY);
    wr(IDX_GT_CONFIG, 8'h03, RESP_OKAY);
    tk(0, 4);
    tk(1, 4);
    tk(2, 2);
    `CHK(ev[2], 0)
    wr(IDX_GT_CONFIG, 8'h02, RESP_OKAY);
    tk(2, 3);
    rd(IDX_GT_CONFIG, 8'h02, RESP_OKAY);
    `CHK(ev[2], 0)
    wr(IDX_GT_CONFIG, 8'h03, RESP_OKAY);
    tk(2, 1);
    `CHK(ev[2], 1)
    rd(IDX_GT_CONFIG, 8'h02, RESP_OKAY);
    // Interrupt raise, mask and clear
    `CHK(irq, 1'b0)
    rd(IDX_STATUS, 8'h04, RESP_OKAY);
    wr(IDX_MASK, 8'h04, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b1)
    wr(IDX_STATUS, 8'h04, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    `CHK(irq, 1'b0)
    rd(IDX_STATUS, 8'h00, RESP_OKAY);
    // Timer two on the RC wake clock, divide by 128, period one
    wr(IDX_GT_PRESCALE, 8'h10, RESP_OKAY);
    wr(IDX_T2_PERIOD, 8'h01, RESP_OKAY);
    wr(IDX_GT_CONFIG, 8'h10, RESP_OKAY);
    tk(2, 5);
    tk(0, 5);
    tk(1, 127);
    `CHK(ev[3], 0)
    tk(1, 1);
    `CHK(ev[3], 1)
    `CHK(irq, 1'b0)
    rd(IDX_STATUS, 8'h08, RESP_OKAY);
    // Timer one on the 2 MHz source, divide by 256, period one
    wr(IDX_GT_PRESCALE, 8'h02, RESP_OKAY);
    wr(IDX_T1_PERIOD, 8'h01, RESP_OKAY);
    wr(IDX_GT_CONFIG, 8'h03, RESP_OKAY);
    tk(2, 255);
    `CHK(ev[2], 1)
    tk(2, 1);
    `CHK(ev[2], 2)
    // Wake interval two ticks, stay-awake one tick, external source
    wr(IDX_INTERVAL_HI, 8'h00, RESP_OKAY);
    wr(IDX_INTERVAL_LO, 8'h02, RESP_OKAY);
    wr(IDX_STAY, 8'h01, RESP_OKAY);
    wr(IDX_WAKE_CTRL, 8'h30, RESP_OKAY);
    tk(0, 1);
    `CHK(ev[0], 0)
    tk(0, 1);
    `CHK(ev[0], 1)
    `CHK(stay, 1'b1)
    tk(0, 1);
    `CHK(ev[1], 1)
    `CHK(stay, 1'b0)
    // Wake divider code 9 halves the source, interval still two
    wr(IDX_WAKE_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_WAKE_PRESCALE, 8'h09, RESP_OKAY);
    wr(IDX_WAKE_CTRL, 8'h10, RESP_OKAY);
    tk(0, 3);
    `CHK(ev[0], 1)
    tk(0, 1);
    `CHK(ev[0], 2)
    wr(IDX_WAKE_CTRL, 8'h04, RESP_OKAY);
    finish_test();
  end
endmodule // wakeup_and_general_timers_tb

`default_nettype wire
